/* design/ctm_pkg.sv */
package ctm_pkg;
	// instance count and per-instance resources
	localparam int CTM_NUM_INST = 4;
	localparam int CTM_NUM_MATCH = 4;
	localparam int CTM_NUM_CAP = 2;
	localparam int CTM_WIDE_W = 32;
	localparam int CTM_NARROW_W = 16;
	localparam int CTM_NUM_WIDE = 2;

	// byte address split: instance select, then word index inside an instance
	localparam int CTM_ADDR_W = 8;
	localparam int CTM_INST_LSB = 6;
	localparam int CTM_IDX_LSB = 2;

	// register word indices inside one instance (byte offset is four times the index)
	localparam logic [3:0] CTM_IDX_FLAG = 4'h0;
	localparam logic [3:0] CTM_IDX_CTRL = 4'h1;
	localparam logic [3:0] CTM_IDX_COUNT = 4'h2;
	localparam logic [3:0] CTM_IDX_PRESCALE = 4'h3;
	localparam logic [3:0] CTM_IDX_PRECOUNT = 4'h4;
	localparam logic [3:0] CTM_IDX_MATCH_CFG = 4'h5;
	localparam logic [3:0] CTM_IDX_CAP_CFG = 4'h6;
	localparam logic [3:0] CTM_IDX_CAPT0 = 4'h7;
	localparam logic [3:0] CTM_IDX_CAPT1 = 4'h8;
	localparam logic [3:0] CTM_IDX_MATCH0 = 4'h9;
	localparam logic [3:0] CTM_IDX_MATCH3 = 4'hC;
	localparam logic [3:0] CTM_IDX_EXT = 4'hD;
	localparam logic [3:0] CTM_IDX_MODE = 4'hE;

	// control register bits
	localparam int CTM_CTRL_EN = 0;
	localparam int CTM_CTRL_HOLD = 1;
	// match config: three bits per match, group k starts at 3*k
	localparam int CTM_MC_INT = 0;
	localparam int CTM_MC_RST = 1;
	localparam int CTM_MC_STOP = 2;
	localparam int CTM_MC_GRP = 3;
	// capture config: three bits per channel
	localparam int CTM_CC_RISE = 0;
	localparam int CTM_CC_FALL = 1;
	localparam int CTM_CC_INT = 2;
	localparam int CTM_CC_GRP = 3;
	// external output register: levels in [3:0], two action bits per match from bit 4
	localparam int CTM_EXT_ACT_LSB = 4;
	// mode register fields
	localparam int CTM_MODE_LSB = 0;
	localparam int CTM_MODE_SRC = 2;
	localparam int CTM_MODE_CLR_EN = 3;
	localparam int CTM_MODE_CLR_CH = 4;
	localparam int CTM_MODE_CLR_FALL = 5;
	// flag register: matches in [3:0], captures in [5:4]
	localparam int CTM_FLAG_CAP_LSB = 4;

	// reset values
	localparam logic [31:0] CTM_RST_WORD = 32'h0000_0000;
	localparam logic [3:0] CTM_RST_EXT = 4'h0;

	typedef enum logic [1:0] {CTM_MODE_TIMER, CTM_MODE_RISE, CTM_MODE_FALL, CTM_MODE_BOTH} ctm_mode_t;
	typedef enum logic [1:0] {CTM_ACT_NONE, CTM_ACT_LOW, CTM_ACT_HIGH, CTM_ACT_TOGGLE} ctm_act_t;
endpackage

/* design/ctm_timer.sv */
`timescale 1ns/100ps
// Operation
// R1: there are four counter/timer instances, two with 32-bit counters and two with 16-bit ones.
// R2: in timer operation the count advances from cycles of the system clock.
// R3: a prescaler as wide as the counter divides the counting clock before the counter.
// R4: each instance runs either as a timer on clock cycles or as a counter on input events.
// R5: each of two capture channels stores the counter into its capture register on an input edge.
// R6: a capture event raises an interrupt request when that channel's interrupt is enabled.
// R7: counter and prescaler can be cleared on a chosen capture edge, for pulse width measurement.
// R8: four match registers are compared with the counter and equality gives a match event.
// R9: by default a match leaves the counter running and interrupts only when enabled.
// R10: with the stop option a match stops the counter, with optional interrupt.
// R11: with the reset option a match resets the counter, with optional interrupt.
// R12: each instance drives four external match outputs, one per match register.
// R13: on a match each output goes low, goes high, toggles or stays, as configured.
// R14: the prescaler counts cycles and advances the counter when it reaches the prescale value.
// R15: each capture channel triggers on rising, falling or both edges.

// one counter/timer instance of width W
module ctm_timer #(
	parameter int W = 32
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [3:0] reg_idx,
	input wire logic [31:0] wdata,
	input wire logic [ctm_pkg::CTM_NUM_CAP-1:0] cap_in,
	output logic [31:0] rd_val,
	output logic [ctm_pkg::CTM_NUM_MATCH-1:0] mat_out,
	output logic irq
);
	localparam int NM = ctm_pkg::CTM_NUM_MATCH;
	localparam int NC = ctm_pkg::CTM_NUM_CAP;

	generate
		if (W < 2 || W > 32) begin : g_bad_width
			$error("ctm_timer: width must be 2 to 32");
		end
		// the match word select and the capture read decode are sized for four and two
		if (NM != 4 || NC != 2) begin : g_bad_count
			$error("ctm_timer: needs four match registers and two capture channels");
		end
	endgenerate

	logic [NC-1:0] cap_s1_r, cap_s2_r, cap_s3_r;
	logic en_r, hold_r;
	logic [W-1:0] tc_r, pc_r, pr_r;
	logic [W-1:0] cr_r [NC];
	logic [W-1:0] mr_r [NM];
	logic [NM*3-1:0] mcfg_r;
	logic [NC*3-1:0] ccfg_r;
	logic [2*NM-1:0] act_r;
	logic [NM-1:0] ext_r, ext_nxt;
	ctm_pkg::ctm_mode_t mode_r;
	logic src_r, clr_en_r, clr_ch_r, clr_fall_r;
	logic [NM+NC-1:0] flag_r, flag_nxt, irq_en;
	logic [W-1:0] tc_nxt, pc_nxt;

	// the first synchroniser stage feeds only the second; edges come from stages two and three
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cap_s1_r <= '0;
			cap_s2_r <= '0;
			cap_s3_r <= '0;
		end else begin
			cap_s1_r <= cap_in;
			cap_s2_r <= cap_s1_r;
			cap_s3_r <= cap_s2_r;
		end
	end

	// edge detection and event decode
	wire [NC-1:0] cap_rise = cap_s2_r & ~cap_s3_r;
	wire [NC-1:0] cap_fall = ~cap_s2_r & cap_s3_r;
	logic [NC-1:0] cap_hit;
	logic [NM-1:0] match_hit, m_rst, m_stop, m_int;
	logic [NC-1:0] c_int;

	always_comb begin
		for (int i = 0; i < NC; i++) begin
			cap_hit[i] = (ccfg_r[i*3+ctm_pkg::CTM_CC_RISE] & cap_rise[i]) | // R5 R15
				(ccfg_r[i*3+ctm_pkg::CTM_CC_FALL] & cap_fall[i]); // R15
			c_int[i] = ccfg_r[i*ctm_pkg::CTM_CC_GRP+ctm_pkg::CTM_CC_INT];
		end
	end

	// counting source: clock cycles, or edges of the chosen capture input
	wire src_rise = cap_rise[src_r];
	wire src_fall = cap_fall[src_r];
	wire ev_in = (mode_r == ctm_pkg::CTM_MODE_RISE) ? src_rise :
		(mode_r == ctm_pkg::CTM_MODE_FALL) ? src_fall :
		(mode_r == ctm_pkg::CTM_MODE_BOTH) ? (src_rise | src_fall) : 1'b0; // R4
	wire is_timer = (mode_r == ctm_pkg::CTM_MODE_TIMER);
	wire step = en_r & ~hold_r & (is_timer | ev_in); // R2 R4
	wire pre_wrap = (pc_r == pr_r); // R14
	wire adv = step & pre_wrap; // R3 R14

	// match compare only when the counter is about to advance, so a value matches once
	always_comb begin
		for (int k = 0; k < NM; k++) begin
			match_hit[k] = adv & (tc_r == mr_r[k]); // R8
			m_int[k] = mcfg_r[k*ctm_pkg::CTM_MC_GRP+ctm_pkg::CTM_MC_INT];
			m_rst[k] = mcfg_r[k*ctm_pkg::CTM_MC_GRP+ctm_pkg::CTM_MC_RST];
			m_stop[k] = mcfg_r[k*ctm_pkg::CTM_MC_GRP+ctm_pkg::CTM_MC_STOP];
		end
	end

	wire do_rst = |(match_hit & m_rst); // R11
	wire do_stop = |(match_hit & m_stop); // R10
	wire clr_cap = clr_en_r & (clr_fall_r ? cap_fall[clr_ch_r] : cap_rise[clr_ch_r]); // R7

	// register write decode
	wire wr_flag = wr_en & (reg_idx == ctm_pkg::CTM_IDX_FLAG);
	wire wr_ctrl = wr_en & (reg_idx == ctm_pkg::CTM_IDX_CTRL);
	wire wr_count = wr_en & (reg_idx == ctm_pkg::CTM_IDX_COUNT);
	wire wr_pre = wr_en & (reg_idx == ctm_pkg::CTM_IDX_PRESCALE);
	wire wr_mcfg = wr_en & (reg_idx == ctm_pkg::CTM_IDX_MATCH_CFG);
	wire wr_ccfg = wr_en & (reg_idx == ctm_pkg::CTM_IDX_CAP_CFG);
	wire wr_ext = wr_en & (reg_idx == ctm_pkg::CTM_IDX_EXT);
	wire wr_mode = wr_en & (reg_idx == ctm_pkg::CTM_IDX_MODE);
	wire wr_mr_any = wr_en & (reg_idx >= ctm_pkg::CTM_IDX_MATCH0) &
		(reg_idx <= ctm_pkg::CTM_IDX_MATCH3);
	wire [3:0] mr_sel = reg_idx - ctm_pkg::CTM_IDX_MATCH0;

	// counter and prescaler next value; hold and capture clear win over counting
	always_comb begin
		tc_nxt = tc_r;
		pc_nxt = pc_r;
		if (hold_r || clr_cap) begin
			tc_nxt = '0; // R7
			pc_nxt = '0; // R7
		end else if (wr_count) begin
			tc_nxt = wdata[W-1:0];
			pc_nxt = '0;
		end else if (step) begin
			pc_nxt = pre_wrap ? '0 : pc_r + 1'b1; // R14
			if (adv) begin
				tc_nxt = do_rst ? '0 : tc_r + 1'b1; // R9 R11
			end
		end
	end

	// output pins: a write sets levels, then any match action that cycle applies on top
	always_comb begin
		ext_nxt = wr_ext ? wdata[NM-1:0] : ext_r;
		for (int k = 0; k < NM; k++) begin
			if (match_hit[k]) begin
				case (ctm_pkg::ctm_act_t'(act_r[2*k +: 2]))
					ctm_pkg::CTM_ACT_LOW: ext_nxt[k] = 1'b0; // R13
					ctm_pkg::CTM_ACT_HIGH: ext_nxt[k] = 1'b1; // R13
					ctm_pkg::CTM_ACT_TOGGLE: ext_nxt[k] = ~ext_nxt[k]; // R13
					default: ext_nxt[k] = ext_nxt[k]; // R13
				endcase
			end
		end
	end

	// sticky flags: a new event in the clearing cycle survives the write-one-to-clear
	assign flag_nxt = (flag_r & ~(wr_flag ? wdata[NM+NC-1:0] : '0)) | {cap_hit, match_hit};
	assign irq_en = {c_int, m_int};
	assign irq = |(flag_r & irq_en); // R6 R9

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tc_r <= '0;
			pc_r <= '0;
			flag_r <= '0;
			ext_r <= ctm_pkg::CTM_RST_EXT;
		end else begin
			tc_r <= tc_nxt;
			pc_r <= pc_nxt;
			flag_r <= flag_nxt;
			ext_r <= ext_nxt; // R12
		end
	end

	// run control: stop on match clears the enable unless software writes it that cycle
	// a stopped counter rests at match plus one, so software reloads the count before a restart
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			en_r <= 1'b0;
			hold_r <= 1'b0;
		end else if (wr_ctrl) begin
			en_r <= wdata[ctm_pkg::CTM_CTRL_EN];
			hold_r <= wdata[ctm_pkg::CTM_CTRL_HOLD];
		end else if (do_stop) begin
			en_r <= 1'b0; // R10
		end
	end

	// configuration registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pr_r <= ctm_pkg::CTM_RST_WORD[W-1:0];
			mcfg_r <= '0;
			ccfg_r <= '0;
			act_r <= '0;
			mode_r <= ctm_pkg::CTM_MODE_TIMER;
			{src_r, clr_en_r, clr_ch_r, clr_fall_r} <= 4'h0;
		end else begin
			if (wr_pre) pr_r <= wdata[W-1:0]; // R3
			if (wr_mcfg) mcfg_r <= wdata[NM*3-1:0];
			if (wr_ccfg) ccfg_r <= wdata[NC*3-1:0];
			if (wr_ext) act_r <= wdata[ctm_pkg::CTM_EXT_ACT_LSB +: 2*NM];
			if (wr_mode) begin
				mode_r <= ctm_pkg::ctm_mode_t'(wdata[ctm_pkg::CTM_MODE_LSB +: 2]); // R4
				src_r <= wdata[ctm_pkg::CTM_MODE_SRC];
				clr_en_r <= wdata[ctm_pkg::CTM_MODE_CLR_EN];
				clr_ch_r <= wdata[ctm_pkg::CTM_MODE_CLR_CH];
				clr_fall_r <= wdata[ctm_pkg::CTM_MODE_CLR_FALL];
			end
		end
	end

	// match and capture word arrays
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int k = 0; k < NM; k++) mr_r[k] <= ctm_pkg::CTM_RST_WORD[W-1:0];
			for (int i = 0; i < NC; i++) cr_r[i] <= ctm_pkg::CTM_RST_WORD[W-1:0];
		end else begin
			for (int k = 0; k < NM; k++) begin
				if (wr_mr_any && mr_sel == 4'(k)) mr_r[k] <= wdata[W-1:0];
			end
			for (int i = 0; i < NC; i++) begin
				if (cap_hit[i]) cr_r[i] <= tc_r; // R5
			end
		end
	end

	assign mat_out = ext_r; // R12

	// read decode; the top registers the selected word
	wire [31:0] mode_word = 32'({clr_fall_r, clr_ch_r, clr_en_r, src_r, mode_r});
	wire [31:0] mr_word = (mr_sel < 4'(NM)) ? 32'(mr_r[mr_sel[1:0]]) : 32'h0000_0000;
	assign rd_val = (reg_idx == ctm_pkg::CTM_IDX_FLAG) ? 32'(flag_r) :
		(reg_idx == ctm_pkg::CTM_IDX_CTRL) ? 32'({hold_r, en_r}) :
		(reg_idx == ctm_pkg::CTM_IDX_COUNT) ? 32'(tc_r) :
		(reg_idx == ctm_pkg::CTM_IDX_PRESCALE) ? 32'(pr_r) :
		(reg_idx == ctm_pkg::CTM_IDX_PRECOUNT) ? 32'(pc_r) :
		(reg_idx == ctm_pkg::CTM_IDX_MATCH_CFG) ? 32'(mcfg_r) :
		(reg_idx == ctm_pkg::CTM_IDX_CAP_CFG) ? 32'(ccfg_r) :
		(reg_idx == ctm_pkg::CTM_IDX_CAPT0) ? 32'(cr_r[0]) :
		(reg_idx == ctm_pkg::CTM_IDX_CAPT1) ? 32'(cr_r[1]) :
		(wr_mr_any | ((reg_idx >= ctm_pkg::CTM_IDX_MATCH0) &
			(reg_idx <= ctm_pkg::CTM_IDX_MATCH3))) ? mr_word :
		(reg_idx == ctm_pkg::CTM_IDX_EXT) ? 32'({act_r, ext_r}) :
		(reg_idx == ctm_pkg::CTM_IDX_MODE) ? mode_word : 32'h0000_0000;
endmodule

// four instances behind one register port
module ctm_top (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [ctm_pkg::CTM_ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [ctm_pkg::CTM_NUM_INST*ctm_pkg::CTM_NUM_CAP-1:0] cap_in,
	output logic [ctm_pkg::CTM_NUM_INST*ctm_pkg::CTM_NUM_MATCH-1:0] mat_out,
	output logic [ctm_pkg::CTM_NUM_INST-1:0] irq
);
	localparam int NI = ctm_pkg::CTM_NUM_INST;
	localparam int NM = ctm_pkg::CTM_NUM_MATCH;
	localparam int NC = ctm_pkg::CTM_NUM_CAP;

	// address split; unaligned accesses are ignored and read as zero
	wire aligned = (addr[1:0] == 2'h0);
	wire [1:0] inst_sel = addr[ctm_pkg::CTM_INST_LSB +: 2];
	wire [3:0] idx = addr[ctm_pkg::CTM_IDX_LSB +: 4];
	logic [31:0] inst_val [NI];
	logic [31:0] rdata_r;

	genvar g;
	generate
		for (g = 0; g < NI; g++) begin : g_inst
			ctm_timer #(
				.W((g < ctm_pkg::CTM_NUM_WIDE) ? ctm_pkg::CTM_WIDE_W : ctm_pkg::CTM_NARROW_W) // R1
			) u_timer (
				.clock(clock),
				.rst_n(rst_n),
				.wr_en(wr & aligned & (inst_sel == 2'(g))),
				.reg_idx(idx),
				.wdata(wdata),
				.cap_in(cap_in[g*NC +: NC]),
				.rd_val(inst_val[g]),
				.mat_out(mat_out[g*NM +: NM]),
				.irq(irq[g])
			);
		end
	endgenerate

	// read data stand only in the cycle after the strobe, zero otherwise
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= (rd & aligned) ? inst_val[inst_sel] : 32'h0000_0000;
		end
	end

	assign rdata = rdata_r;
endmodule

/* testbench/ctm_sva.sv */
`timescale 1ns/100ps
// port-level checks on the whole block; one clock domain
module ctm_sva (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic [7:0] cap_in,
	input wire logic [15:0] mat_out,
	input wire logic [3:0] irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	// read data may only show in the cycle after a read strobe
	rd_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data outside the read slot");
	unaligned_a: assert property (rd && addr[1:0] != 2'h0 |=> rdata == 32'h0)
		else $error("unaligned read returned data");
	unused_idx_a: assert property (rd && addr[5:2] == 4'hF |=> rdata == 32'h0)
		else $error("unused word returned data");
	narrow_a: assert property (rd && addr[7] |=> rdata[31:16] == 16'h0)
		else $error("narrow instance upper half not zero");
	// a request only drops after software cleared a flag or an enable
	irq_clear_a: assert property (|(~irq & $past(irq)) |-> $past(wr))
		else $error("interrupt dropped with no write");
	ctrl_bits_a: assert property (rd && addr[5:2] == ctm_pkg::CTM_IDX_CTRL
		|=> rdata[31:2] == 30'h0) else $error("control reads stray bits");
	flag_bits_a: assert property (rd && addr[5:2] == ctm_pkg::CTM_IDX_FLAG
		|=> rdata[31:6] == 26'h0) else $error("flags read stray bits");
	// outputs are quiet while reset is held, so no default disable here
	reset_out_a: assert property (disable iff (1'b0) !rst_n
		|-> mat_out == 16'h0 && irq == 4'h0 && rdata == 32'h0) else $error("outputs busy in reset");
endmodule

/* testbench/ctm_pins.sv */
`timescale 1ns/100ps
// capture pin source: idle low, one high pulse of len clocks per start
module ctm_pins (
	input wire logic clock,
	input wire logic start,
	input wire logic [7:0] len,
	output logic pin,
	output logic busy
);
	logic [7:0] left_r = 8'h0;

	// pin moves only just after an edge, as a clocked source would
	always_ff @(posedge clock) begin
		if (start) begin
			left_r <= len;
		end else if (left_r != 8'h0) begin
			left_r <= left_r - 8'h1;
		end
	end
	assign pin = left_r != 8'h0;
	assign busy = pin;
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/100ps
// register-port driver plus one capture pin shared by every channel
module tb_top;
	logic clock;
	logic rst_n;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic [15:0] mat_out;
	logic [3:0] irq;
	logic start;
	logic [7:0] len;
	logic pin;
	logic busy;
	logic [31:0] v;
	logic [31:0] w;
	logic [15:0] lf;
	int failures;
	int checks_done;
	int cyc;
	int t0;
	int t1;
	int p;
	int m;

	ctm_top dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .cap_in({8{pin}}), .mat_out(mat_out), .irq(irq));
	ctm_pins u_pins (.clock(clock), .start(start), .len(len), .pin(pin), .busy(busy));

	// clock and a cycle count for measuring periods
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) cyc <= cyc + 1;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [7:0] ra(input int g, input int i);
		return {g[1:0], i[3:0], 2'h0};
	endfunction
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	// data stands only in the cycle after the strobe, so sample just past that edge
	task automatic rreg(input logic [7:0] a);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		if (failures == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// polls off the edge so the registered output has settled
	task automatic wait_bit(input int b);
		logic o;
		int n;
		#1 o = mat_out[b];
		n = 0;
		while (mat_out[b] === o && n < 500) begin
			#10 n++;
		end
		t0 = cyc;
		if (n >= 500) begin
			failures++;
			stop_test();
		end
	endtask
	// pulse, then leave room for the three-edge input latency
	task automatic pulse();
		int n;
		@(posedge clock);
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		// step off the edge so the pin model's new count is visible
		#1;
		for (n = 0; n < 300 && busy === 1'b1; n++) @(posedge clock);
		if (n >= 300) begin
			failures++;
			stop_test();
		end
		repeat (4) @(posedge clock);
	endtask

	initial begin
		#500000 failures++;
		stop_test();
	end

	initial begin
		rst_n = 1'b1;
		addr = 8'h0;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		start = 1'b0;
		len = 8'h0;
		lf = 16'hB5BD;
		// a real falling edge after time zero, so the asynchronous reset is never missed
		#1 rst_n = 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		// every word starts at zero; unused and unaligned places read zero
		for (int g = 0; g < 4; g++) begin
			for (int i = 0; i < 16; i++) begin
				rreg(ra(g, i));
				chk(v, 32'h0);
			end
		end
		rreg(8'h45);
		chk(v, 32'h0);
		// reset plus toggle: the output toggles every (match+1)*(prescale+1) cycles on both widths
		for (int g = 0; g < 4; g += 2) begin
			lf = lfsr(lf);
			p = lf % 4;
			m = 1 + lf[7:4] % 4;
			wreg(ra(g, ctm_pkg::CTM_IDX_PRESCALE), p);
			wreg(ra(g, ctm_pkg::CTM_IDX_MATCH0), m);
			wreg(ra(g, ctm_pkg::CTM_IDX_MATCH_CFG), 32'h3);
			wreg(ra(g, ctm_pkg::CTM_IDX_EXT), 32'h30);
			wreg(ra(g, ctm_pkg::CTM_IDX_CTRL), 32'h1);
			wait_bit(4 * g);
			t1 = t0;
			wait_bit(4 * g);
			chk(t0 - t1, (m + 1) * (p + 1));
			chk({31'h0, irq[g]}, 32'h1);
			wreg(ra(g, ctm_pkg::CTM_IDX_CTRL), 32'h0);
			wreg(ra(g, ctm_pkg::CTM_IDX_FLAG), 32'hF);
			#1 chk({31'h0, irq[g]}, 32'h0);
		end
		// one count hits all four matches: none, low, high, toggle; match three stops
		for (int k = 0; k < 4; k++) wreg(ra(3, ctm_pkg::CTM_IDX_MATCH0 + k), 32'h4);
		wreg(ra(3, ctm_pkg::CTM_IDX_MATCH_CFG), 32'h801);
		wreg(ra(3, ctm_pkg::CTM_IDX_EXT), 32'hE43);
		wreg(ra(3, ctm_pkg::CTM_IDX_CTRL), 32'h1);
		wait_bit(13);
		chk({28'h0, mat_out[15:12]}, 32'hD);
		chk({31'h0, irq[3]}, 32'h1);
		rreg(ra(3, ctm_pkg::CTM_IDX_CTRL));
		chk(v, 32'h0);
		rreg(ra(3, ctm_pkg::CTM_IDX_FLAG));
		chk(v, 32'hF);
		rreg(ra(3, ctm_pkg::CTM_IDX_COUNT));
		w = v;
		rreg(ra(3, ctm_pkg::CTM_IDX_COUNT));
		chk(v, w);
		chk(v, 32'h5);
		// rising into capture 0, falling into capture 1: the gap is the pulse length
		wreg(ra(1, ctm_pkg::CTM_IDX_CAP_CFG), 32'h15);
		wreg(ra(1, ctm_pkg::CTM_IDX_CTRL), 32'h1);
		lf = lfsr(lf);
		len <= 8'h3 + {5'h0, lf[2:0]};
		pulse();
		rreg(ra(1, ctm_pkg::CTM_IDX_CAPT1));
		w = v;
		rreg(ra(1, ctm_pkg::CTM_IDX_CAPT0));
		chk(w - v, {24'h0, len});
		chk({31'h0, irq[1]}, 32'h1);
		// clearing on the rising edge leaves len-1 in the falling capture
		wreg(ra(1, ctm_pkg::CTM_IDX_MODE), 32'h8);
		pulse();
		rreg(ra(1, ctm_pkg::CTM_IDX_CAPT1));
		chk(v, {24'h0, len} - 32'h1);
		// counting on both pin edges: two steps per pulse
		wreg(ra(1, ctm_pkg::CTM_IDX_MODE), 32'h3);
		wreg(ra(1, ctm_pkg::CTM_IDX_COUNT), 32'h0);
		repeat (3) pulse();
		rreg(ra(1, ctm_pkg::CTM_IDX_COUNT));
		chk(v, 32'h6);
		// falling edges only, taken from the second input: one step per pulse
		wreg(ra(1, ctm_pkg::CTM_IDX_MODE), 32'h6);
		pulse();
		rreg(ra(1, ctm_pkg::CTM_IDX_COUNT));
		chk(v, 32'h7);
		stop_test();
	end
endmodule

bind ctm_top ctm_sva u_sva (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
	.rd(rd), .rdata(rdata), .cap_in(cap_in), .mat_out(mat_out), .irq(irq));
